// [dcce_pkg.sv]
package dcce_pkg;
	localparam logic [11:0] HT_ENABLE_IDX = 12'h024;
	localparam logic [11:0] HEC_ENABLE_IDX = 12'h026;
	localparam logic [11:0] MEM_ENABLE_IDX = 12'h028;
	localparam logic [11:0] HT_ENABLE_ADDR = HT_ENABLE_IDX << 2;
	localparam logic [11:0] HEC_ENABLE_ADDR = HEC_ENABLE_IDX << 2;
	localparam logic [11:0] MEM_ENABLE_ADDR = MEM_ENABLE_IDX << 2;
	localparam logic [11:0] HT_COUNT_ADDR = 12'h100;
	localparam logic [11:0] HEC_COUNT_ADDR = 12'h104;
	localparam logic [11:0] MEM_COUNT_ADDR = 12'h108;
	localparam logic [11:0] MODE_ADDR = 12'h10c;
	localparam int unsigned EN_BIT = 7;
	localparam int unsigned CLEAR_BIT = 6;
	localparam int unsigned PORT_LSB = 0;
	localparam int unsigned PORT_W = 5;
	localparam int unsigned CTRL_SHORT_BIT = 15;
	localparam int unsigned BUF_SHORT_BIT = 14;
	localparam int unsigned PASS_BIT = 0;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [15:0] SEL_WMASK = 16'h00df;
	localparam logic [15:0] MEM_WMASK = 16'hc0c0;
	localparam logic [15:0] MODE_WMASK = 16'h0001;
	localparam logic [4:0] PORT_LAST = 5'h1d;
	localparam logic [4:0] PORT_RSVD = 5'h1e;
	localparam logic [4:0] PORT_ALL = 5'h1f;
	typedef enum logic [1:0] {
		DCCE_IDLE = 2'b00,
		DCCE_ACK = 2'b01
	} dcce_apb_e;
endpackage

// [dcce_port_match.sv]
`timescale 1ns/1ps
module dcce_port_match (
	input wire logic [4:0] portSel,
	input wire logic [4:0] cellPort,
	input wire logic allOnly,
	output logic matchOut
);
	// Causes flagged allOnly are counted only by the all-ports selector.
	always_comb
	begin
		matchOut = 1'b0;
		if (portSel == dcce_pkg::PORT_ALL)
			matchOut = 1'b1;
		else if (portSel <= dcce_pkg::PORT_LAST)
			matchOut = (portSel == cellPort) && !allOnly;
	end
endmodule // dcce_port_match

// [dcce_counter.sv]
`timescale 1ns/1ps
module dcce_counter #(
	parameter int unsigned CNT_W = 32
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic clear,
	input wire logic hit,
	output logic [CNT_W-1:0] count
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
	} dcce_cnt_s;
	dcce_cnt_s cnt_r;
	dcce_cnt_s cnt_nxt;

	// Clear comes first, so an event in the clearing cycle leaves one if enable is high, zero if it is low.
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (clear)
			cnt_nxt.count = '0;
		if (enable && hit)
			cnt_nxt.count = cnt_nxt.count + 1'b1;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign count = cnt_r.count;

	a_reset_zero: assert property (@(posedge ref_clk) $rose(rst_n) |-> count == '0)
		else $error("counter not zero after reset");
	a_clear_then: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clear |=> count == (($past(enable) && $past(hit)) ? 1 : 0))
		else $error("clear did not restart the counter");
endmodule // dcce_counter

// [dcce_top.sv]
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module dcce_top #(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned CNT_W = 32
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic htDiscard,
	input wire logic [4:0] htPort,
	input wire logic invalidInputPortCause,
	input wire logic inputMismatchCause,
	input wire logic hecCrcDiscard,
	input wire logic hecCell,
	input wire logic [4:0] hecPort,
	input wire logic controlAreaShortDiscard,
	input wire logic cellBufferShortDiscard,
	output logic [CNT_W-1:0] hdrXlatErrDiscardCounter,
	output logic [CNT_W-1:0] hecCrcErrDiscardCounter,
	output logic [CNT_W-1:0] memShortDiscardCounter
);
	typedef struct packed {
		dcce_pkg::dcce_apb_e apbState;
		logic ready;
		logic slvErr;
		logic [31:0] rdata;
		logic [15:0] hdrXlatErrCountEnable;
		logic [15:0] hecCrcErrCountEnable;
		logic [15:0] memShortCountEnable;
		logic [15:0] firstModeRegister;
	} dcce_top_s;
	dcce_top_s st_r;
	dcce_top_s st_nxt;

	logic [11:0] addr;
	logic accessOk;
	logic wrDone;
	logic mapped;
	logic [31:0] readMux;
	logic htMatch;
	logic hecMatch;
	logic htHit;
	logic hecHit;
	logic memHit;
	logic htClear;
	logic hecClear;
	logic memClear;
	logic htEnable;
	logic hecEnable;
	logic memEnable;
	logic headerErrorPass;
	logic [4:0] htSel;
	logic [4:0] hecSel;

	function automatic logic dcceIsClearWrite(input logic [31:0] data);
		return data[dcce_pkg::EN_BIT] && data[dcce_pkg::CLEAR_BIT];
	endfunction

	function automatic logic [31:0] dcceWord(input logic [15:0] value);
		return {16'h0000, value};
	endfunction

	assign addr = 12'(paddr);
	assign accessOk = psel && penable;
	assign wrDone = (st_r.apbState == dcce_pkg::DCCE_ACK) && accessOk && pwrite;

	always_comb
	begin
		mapped = 1'b1;
		readMux = 32'h0000_0000;
		case (addr)
			dcce_pkg::HT_ENABLE_ADDR: readMux = dcceWord(st_r.hdrXlatErrCountEnable);
			dcce_pkg::HEC_ENABLE_ADDR: readMux = dcceWord(st_r.hecCrcErrCountEnable);
			dcce_pkg::MEM_ENABLE_ADDR: readMux = dcceWord(st_r.memShortCountEnable);
			dcce_pkg::MODE_ADDR: readMux = dcceWord(st_r.firstModeRegister);
			dcce_pkg::HT_COUNT_ADDR: readMux = 32'(hdrXlatErrDiscardCounter);
			dcce_pkg::HEC_COUNT_ADDR: readMux = 32'(hecCrcErrDiscardCounter);
			dcce_pkg::MEM_COUNT_ADDR: readMux = 32'(memShortDiscardCounter);
			default: mapped = 1'b0;
		endcase
		if (ADDR_W > 12 && (paddr >> 12) != '0)
			mapped = 1'b0;
	end

	// Software only reaches 11 after parking EN at 0, so the clear is
	// taken on the write that lands 11 and the count restarts from zero.
	assign htClear = wrDone && addr == dcce_pkg::HT_ENABLE_ADDR && dcceIsClearWrite(pwdata);
	assign hecClear = wrDone && addr == dcce_pkg::HEC_ENABLE_ADDR && dcceIsClearWrite(pwdata);
	assign memClear = wrDone && addr == dcce_pkg::MEM_ENABLE_ADDR && dcceIsClearWrite(pwdata);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ready = 1'b0;
		case (st_r.apbState)
			dcce_pkg::DCCE_IDLE:
			begin
				if (accessOk)
				begin
					st_nxt.apbState = dcce_pkg::DCCE_ACK;
					st_nxt.ready = 1'b1;
					st_nxt.slvErr = !mapped;
					st_nxt.rdata = pwrite ? 32'h0000_0000 : readMux;
				end
			end
			dcce_pkg::DCCE_ACK:
			begin
				st_nxt.apbState = dcce_pkg::DCCE_IDLE;
				st_nxt.slvErr = 1'b0;
				if (wrDone)
				begin
					case (addr)
						dcce_pkg::HT_ENABLE_ADDR:
							st_nxt.hdrXlatErrCountEnable = pwdata[15:0] & dcce_pkg::SEL_WMASK;
						dcce_pkg::HEC_ENABLE_ADDR:
							st_nxt.hecCrcErrCountEnable = pwdata[15:0] & dcce_pkg::SEL_WMASK;
						dcce_pkg::MEM_ENABLE_ADDR:
							st_nxt.memShortCountEnable = pwdata[15:0] & dcce_pkg::MEM_WMASK;
						dcce_pkg::MODE_ADDR:
							st_nxt.firstModeRegister = pwdata[15:0] & dcce_pkg::MODE_WMASK;
						default:
							st_nxt.firstModeRegister = st_r.firstModeRegister;
					endcase
				end
			end
			default:
			begin
				st_nxt.apbState = dcce_pkg::DCCE_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r.apbState <= dcce_pkg::DCCE_IDLE;
			st_r.ready <= 1'b0;
			st_r.slvErr <= 1'b0;
			st_r.rdata <= 32'h0000_0000;
			st_r.hdrXlatErrCountEnable <= dcce_pkg::REG_RST;
			st_r.hecCrcErrCountEnable <= dcce_pkg::REG_RST;
			st_r.memShortCountEnable <= dcce_pkg::REG_RST;
			st_r.firstModeRegister <= dcce_pkg::REG_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.slvErr;

	assign htEnable = st_r.hdrXlatErrCountEnable[dcce_pkg::EN_BIT];
	assign hecEnable = st_r.hecCrcErrCountEnable[dcce_pkg::EN_BIT];
	assign memEnable = st_r.memShortCountEnable[dcce_pkg::EN_BIT];
	assign headerErrorPass = st_r.firstModeRegister[dcce_pkg::PASS_BIT];
	assign htSel = st_r.hdrXlatErrCountEnable[dcce_pkg::PORT_LSB +: dcce_pkg::PORT_W];
	assign hecSel = st_r.hecCrcErrCountEnable[dcce_pkg::PORT_LSB +: dcce_pkg::PORT_W];

	dcce_port_match u_htMatch (
		.portSel(htSel),
		.cellPort(htPort),
		.allOnly(invalidInputPortCause || inputMismatchCause),
		.matchOut(htMatch)
	);

	dcce_port_match u_hecMatch (
		.portSel(hecSel),
		.cellPort(hecPort),
		.allOnly(1'b0),
		.matchOut(hecMatch)
	);

	// A passed HEC-error cell is forwarded, so it is no discard at all.
	assign htHit = htDiscard && htMatch;
	assign hecHit = hecCrcDiscard && hecMatch && !(hecCell && headerErrorPass);
	assign memHit = (controlAreaShortDiscard
		&& st_r.memShortCountEnable[dcce_pkg::CTRL_SHORT_BIT])
		|| (cellBufferShortDiscard && st_r.memShortCountEnable[dcce_pkg::BUF_SHORT_BIT]);

	dcce_counter #(
		.CNT_W(CNT_W)
	) u_htCount (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enable(htEnable),
		.clear(htClear),
		.hit(htHit),
		.count(hdrXlatErrDiscardCounter)
	);

	dcce_counter #(
		.CNT_W(CNT_W)
	) u_hecCount (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enable(hecEnable),
		.clear(hecClear),
		.hit(hecHit),
		.count(hecCrcErrDiscardCounter)
	);

	dcce_counter #(
		.CNT_W(CNT_W)
	) u_memCount (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enable(memEnable),
		.clear(memClear),
		.hit(memHit),
		.count(memShortDiscardCounter)
	);

	default clocking cb_main @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_access;
		psel && penable && !pready;
	endsequence

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	a_apb_answer: assert property (s_access |=> s_answer)
		else $error("APB access not answered in one wait cycle");

	a_ht_count_step: assert property (htEnable && !htClear && htHit
		|=> hdrXlatErrDiscardCounter == $past(hdrXlatErrDiscardCounter) + 1'b1)
		else $error("header error discard not counted once");

	a_ht_disabled: assert property (!htEnable && !htClear
		|=> hdrXlatErrDiscardCounter == $past(hdrXlatErrDiscardCounter))
		else $error("header error counter moved while disabled");

	a_ht_port_one: assert property (htDiscard && htSel <= dcce_pkg::PORT_LAST
		&& (htPort != htSel || inputMismatchCause) && !htClear
		|=> hdrXlatErrDiscardCounter == $past(hdrXlatErrDiscardCounter))
		else $error("foreign port or mismatch cause counted");

	a_ht_all_ports: assert property (htDiscard && htEnable && htSel == dcce_pkg::PORT_ALL
		&& !htClear |=> hdrXlatErrDiscardCounter == $past(hdrXlatErrDiscardCounter) + 1'b1)
		else $error("all-ports selector missed a discard");

	a_ht_reserved: assert property (htSel == dcce_pkg::PORT_RSVD && !htClear
		|=> hdrXlatErrDiscardCounter == $past(hdrXlatErrDiscardCounter))
		else $error("reserved selector counted");

	a_hec_disabled: assert property (!hecEnable && !hecClear
		|=> hecCrcErrDiscardCounter == $past(hecCrcErrDiscardCounter))
		else $error("HEC/CRC counter moved while disabled");

	a_hec_pass: assert property (hecCrcDiscard && hecCell && headerErrorPass && !hecClear
		|=> hecCrcErrDiscardCounter == $past(hecCrcErrDiscardCounter))
		else $error("passed HEC cell was counted");

	a_hec_port: assert property (hecCrcDiscard && hecEnable && !hecCell && hecSel == hecPort
		&& hecSel <= dcce_pkg::PORT_LAST && !hecClear
		|=> hecCrcErrDiscardCounter == $past(hecCrcErrDiscardCounter) + 1'b1)
		else $error("selected HEC/CRC port not counted");

	a_mem_control: assert property (controlAreaShortDiscard && !cellBufferShortDiscard
		&& memEnable && !memClear |=> memShortDiscardCounter
		== $past(memShortDiscardCounter) + ($past(st_r.memShortCountEnable[15]) ? 1 : 0))
		else $error("control area shortage count wrong");

	a_mem_buffer: assert property (cellBufferShortDiscard && !controlAreaShortDiscard
		&& memEnable && !memClear |=> memShortDiscardCounter
		== $past(memShortDiscardCounter) + ($past(st_r.memShortCountEnable[14]) ? 1 : 0))
		else $error("cell buffer shortage count wrong");

	a_mem_clear: assert property (memClear && !memHit
		|=> memShortDiscardCounter == '0 ##1 memEnable)
		else $error("shortage clear did not zero and enable");

	a_apb_quiet: assert property (!psel |=> !pready)
		else $error("APB answer without a selected access");

	a_apb_error: assert property (pslverr |-> pready)
		else $error("APB error shown outside an answer");

	a_ht_port_hit: assert property (htDiscard && htEnable && htSel == htPort
		&& htSel <= dcce_pkg::PORT_LAST && !invalidInputPortCause && !inputMismatchCause
		&& !htClear |=> hdrXlatErrDiscardCounter == $past(hdrXlatErrDiscardCounter) + 1'b1)
		else $error("selected header error port not counted");

	a_ht_invalid_port: assert property (htDiscard && invalidInputPortCause
		&& htSel != dcce_pkg::PORT_ALL && !htClear
		|=> hdrXlatErrDiscardCounter == $past(hdrXlatErrDiscardCounter))
		else $error("invalid port cause counted by one-port selector");

	a_ht_clear: assert property (htClear && !htEnable
		|=> hdrXlatErrDiscardCounter == '0)
		else $error("header error counter not cleared");

	a_hec_clear: assert property (hecClear && !hecEnable
		|=> hecCrcErrDiscardCounter == '0)
		else $error("HEC/CRC counter not cleared");

	a_hec_count_step: assert property (hecEnable && !hecClear && hecHit
		|=> hecCrcErrDiscardCounter == $past(hecCrcErrDiscardCounter) + 1'b1)
		else $error("HEC/CRC discard not counted once");

	a_hec_all_ports: assert property (hecCrcDiscard && hecEnable
		&& hecSel == dcce_pkg::PORT_ALL && !(hecCell && headerErrorPass) && !hecClear
		|=> hecCrcErrDiscardCounter == $past(hecCrcErrDiscardCounter) + 1'b1)
		else $error("all-ports HEC/CRC selector missed a discard");

	a_hec_reserved: assert property (hecSel == dcce_pkg::PORT_RSVD && !hecClear
		|=> hecCrcErrDiscardCounter == $past(hecCrcErrDiscardCounter))
		else $error("reserved HEC/CRC selector counted");

	a_hec_foreign: assert property (hecCrcDiscard && hecSel <= dcce_pkg::PORT_LAST
		&& hecPort != hecSel && !hecClear
		|=> hecCrcErrDiscardCounter == $past(hecCrcErrDiscardCounter))
		else $error("foreign HEC/CRC port counted");

	a_mem_disabled: assert property (!memEnable && !memClear
		|=> memShortDiscardCounter == $past(memShortDiscardCounter))
		else $error("shortage counter moved while disabled");

	a_mem_count_step: assert property (memEnable && !memClear && memHit
		|=> memShortDiscardCounter == $past(memShortDiscardCounter) + 1'b1)
		else $error("shortage discard not counted once");

	a_mem_ctrl_off: assert property (controlAreaShortDiscard && !cellBufferShortDiscard
		&& !st_r.memShortCountEnable[dcce_pkg::CTRL_SHORT_BIT] && !memClear
		|=> memShortDiscardCounter == $past(memShortDiscardCounter))
		else $error("control area shortage counted while off");

	a_mem_buf_off: assert property (cellBufferShortDiscard && !controlAreaShortDiscard
		&& !st_r.memShortCountEnable[dcce_pkg::BUF_SHORT_BIT] && !memClear
		|=> memShortDiscardCounter == $past(memShortDiscardCounter))
		else $error("cell buffer shortage counted while off");

	a_mem_both: assert property (controlAreaShortDiscard && cellBufferShortDiscard
		&& memEnable && memHit && !memClear
		|=> memShortDiscardCounter == $past(memShortDiscardCounter) + 1'b1)
		else $error("double shortage cause not counted as one cell");
endmodule // dcce_top

// [dcce_tb_top.sv]
`timescale 1ns/1ps
module dcce_tb_top;
	localparam logic [11:0] AD [4] = '{dcce_pkg::HT_ENABLE_ADDR, dcce_pkg::HEC_ENABLE_ADDR,
		dcce_pkg::MEM_ENABLE_ADDR, dcce_pkg::MODE_ADDR};
	localparam logic [15:0] MK [4] = '{16'h00df, 16'h00df, 16'hc0c0, 16'h0001};
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic htDiscard = 1'h0;
	logic [4:0] htPort = 5'h00;
	logic invalidInputPortCause = 1'h0;
	logic inputMismatchCause = 1'h0;
	logic hecCrcDiscard = 1'h0;
	logic hecCell = 1'h0;
	logic [4:0] hecPort = 5'h00;
	logic controlAreaShortDiscard = 1'h0;
	logic cellBufferShortDiscard = 1'h0;
	logic [31:0] cnt [3];
	logic [31:0] e [3] = '{default: 32'h0};
	logic [15:0] sh [4] = '{default: 16'h0};
	logic [31:0] lfsr = 32'h1ae8bb76;
	logic [31:0] rd;
	logic [31:0] cr;
	logic [4:0] cs;
	logic err;
	int badCount = 0;
	int testsRun = 0;

	dcce_top dcce_top_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .htDiscard, .htPort, .invalidInputPortCause, .inputMismatchCause,
		.hecCrcDiscard, .hecCell, .hecPort, .controlAreaShortDiscard, .cellBufferShortDiscard,
		.hdrXlatErrDiscardCounter(cnt[0]), .hecCrcErrDiscardCounter(cnt[1]),
		.memShortDiscardCounter(cnt[2]));

	initial
		forever #10 ref_clk = ~ref_clk;

	function logic [31:0] rnd();
		lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
		return lfsr;
	endfunction

	// Works out which counters the event inputs now on the pins should advance.
	function logic [2:0] hits();
		logic [4:0] a;
		logic [4:0] b;
		a = sh[0][4:0];
		b = sh[1][4:0];
		hits[0] = htDiscard && sh[0][7] && (a == 5'h1f || (a != 5'h1e && a == htPort
			&& !invalidInputPortCause && !inputMismatchCause));
		hits[1] = hecCrcDiscard && sh[1][7] && !(hecCell && sh[3][0])
			&& (b == 5'h1f || (b != 5'h1e && b == hecPort));
		hits[2] = sh[2][7] && ((controlAreaShortDiscard && sh[2][15])
			|| (cellBufferShortDiscard && sh[2][14]));
	endfunction

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			badCount++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task complete_run();
		$display("Comparisons %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'h1);
		check("pready wait", 32'(n), 32'h2);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask

	// A clear is only made after a write with counting off, as software must do it.
	task prog(input int k, input logic [15:0] v);
		if (k < 3 && v[7:6] == 2'b11)
			apb(1'h1, AD[k], {16'h0, v & 16'hff7f});
		apb(1'h1, AD[k], {16'h0, v});
		sh[k] = v & MK[k];
		if (k < 3 && v[7:6] == 2'b11)
			e[k] = 32'h0;
		apb(1'h0, AD[k], 32'h0);
		check("enable readback", rd, {16'h0, v & MK[k]});
		check("readback error", {31'h0, err}, 32'h0);
	endtask

	// Counters seen at an edge still hold the events sampled at earlier edges only.
	task step(input logic go);
		logic [31:0] r;
		logic [2:0] h;
		h = hits();
		for (int k = 0; k < 3; k++)
		begin
			check("discard count", cnt[k], e[k]);
			e[k] = e[k] + 32'(h[k]);
		end
		r = go ? rnd() : 32'h0;
		htDiscard <= r[0];
		htPort <= r[1] ? sh[0][4:0] : r[6:2];
		invalidInputPortCause <= r[7] & r[8];
		inputMismatchCause <= r[9] & r[10];
		hecCrcDiscard <= r[11];
		hecCell <= r[12];
		hecPort <= r[13] ? sh[1][4:0] : r[18:14];
		controlAreaShortDiscard <= r[19];
		cellBufferShortDiscard <= r[20];
		@(posedge ref_clk);
	endtask

	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'h1;
		@(posedge ref_clk);
		for (int j = 0; j < 2; j++)
		begin
			for (int k = 0; k < 4; k++)
			begin
				apb(1'h0, AD[k], 32'h0);
				check("reset value", rd, 32'h0);
			end
			apb(1'h1, dcce_pkg::HT_COUNT_ADDR, 32'hffffffff);
			check("count write error", {31'h0, err}, 32'h0);
			step(1'h0);
			apb(1'h1, 12'hffc, 32'hffffffff);
			check("slave error", {31'h0, err}, 32'h1);
			apb(1'h0, 12'hffc, 32'h0);
			check("unmapped read", rd, 32'h0);
			check("read error", {31'h0, err}, 32'h1);
			for (int i = 0; i < 12; i++)
			begin
				cr = rnd();
				cs = i == 0 ? 5'h1f : i == 1 ? 5'h1e : i == 2 ? 5'h1d : i == 3 ? 5'h00 : cr[4:0];
				prog(0, {cr[31:24], i != 4, cr[5], cr[13], cs});
				prog(1, {cr[23:16], i != 6, cr[6], cr[14],
					i == 5 ? 5'h1e : i < 4 ? ~cs : cr[11:7]});
				prog(2, {i[1:0], cr[29:24], i != 7, cr[7], cr[13:8]});
				prog(3, {cr[15:1], i[0]});
				repeat (40) step(1'h1);
				step(1'h0);
				step(1'h0);
				for (int k = 0; k < 3; k++)
				begin
					apb(1'h0, dcce_pkg::HT_COUNT_ADDR + 12'(4 * k), 32'h0);
					check("count register", rd, e[k]);
				end
				$display("Config %0d of pass %0d done", i, j);
			end
			rst_n <= 1'h0;
			repeat (2) @(posedge ref_clk);
			rst_n <= 1'h1;
			sh = '{default: 16'h0};
			e = '{default: 32'h0};
			@(posedge ref_clk);
		end
		complete_run();
	end

	initial
	begin
		repeat (30000) @(posedge ref_clk);
		badCount++;
		complete_run();
	end
endmodule // dcce_tb_top
